// *** dpsem_dev.sv ***
/*
 Model of one memory port of the dual-port device, seen from the left.
 Assumes the bench acts for the far port through hierarchical pokes.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsem_dev (
  input wire logic clk, // sample clock
  input wire logic en_n, // memory enable, low
  input wire logic en_h, // memory enable, high
  input wire logic tok_n, // token space select, low
  input wire logic rw_n, // write strobe, low
  input wire logic oe_n, // output enable, low
  input wire logic [15:0] addr, // address
  input wire logic [17:0] din, // data wire level
  input wire logic role, // high: device arbitrates
  input wire logic wo_n, // host wait drive
  input wire logic woe_n, // host wait enable, low
  output logic [17:0] dout, // device data drive
  output logic wait_n, // wait wire level
  output logic mbox_n // left mailbox flag
);
  logic [17:0] mem [65536];
  logic [1:0] hold [8];
  logic req [3][8];
  logic [17:0] last = '0;
  logic opp_en = 0;
  logic rflag_n = 1;
  logic [15:0] opp_addr = '0;
  wire sel = !en_n && en_h;
  wire [2:0] ti = addr[2:0];
  initial begin
    mbox_n = 0;
    foreach (hold[i]) hold[i] = 0;
    foreach (mem[i]) mem[i] = '0;
    foreach (req[s, i]) req[s][i] = 0;
  end
  // with role high, far port enabled on the same word always wins, whichever settled first; its own wait stays high
  assign wait_n = role ? !(opp_en && sel && opp_addr == addr)
                       : (woe_n | wo_n);
  // s: 1 left, 2 right
  task automatic tok_wr(input int s, input int i, input logic b);
    if (!b && hold[i] == 0) hold[i] = 2'(s);
    else if (!b && hold[i] != s) req[s][i] = 1;
    else if (b && hold[i] == s) begin
      hold[i] = req[3-s][i] ? 2'(3 - s) : 2'h0;
      req[3-s][i] = 0;
    end else if (b) req[s][i] = 0;
  endtask
  // far port writes a word; its write to the left mailbox raises the left flag
  task far_wr(input logic [15:0] a, input logic [17:0] d);
    mem[a] <= d;
    if (a == 16'hFFFE) mbox_n <= 0;
  endtask
  always_comb begin
    if (!oe_n && !tok_n && en_n) dout = {18{hold[ti] != 1}};
    else if (!oe_n && sel) dout = mem[addr];
    else dout = ~last;
  end
  always @(posedge clk) begin
    last <= dout;
    if (sel && !rw_n && wait_n) mem[addr] <= din;
    if (sel && !rw_n && wait_n && addr == 16'hFFFF) rflag_n <= 0;
    if (sel && !oe_n && addr == 16'hFFFE) mbox_n <= 1;
    if (!tok_n && en_n && !rw_n) tok_wr(1, ti, din[0]);
  end
endmodule
`default_nettype wire

// *** dpsem_host.sv ***
/*
 Host controller driving one port of the dual-port memory: memory and
 token accesses, mailbox use, wait handling and role control, ordered
 by software over APB. Assumes pins from the memory are asynchronous.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsem_host #(
  parameter int NDEV = 1,
  parameter bit LEFT_PORT = 1'b1
) (
  input wire logic pclk, // apb clock
  input wire logic presetn, // async reset, low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [7:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error
  output logic port_select_low_active_n, // memory enable, low
  output logic port_select_high_active, // memory enable, high
  output logic token_space_select_n, // token space select, low
  output logic rw_n, // write strobe, low
  output logic oe_n, // output enable, low
  output logic [dpsem_pkg::AW-1:0] addr, // address pins
  input wire logic [dpsem_pkg::DW-1:0] data_in, // data pin level
  output logic [dpsem_pkg::DW-1:0] data_out, // data pin drive
  output logic data_oe_n, // data drive enable, low
  input wire logic [NDEV-1:0] collision_wait_in_n, // wait pin level per device
  output logic collision_wait_out_n, // wait pin drive
  output logic collision_wait_oe_n, // wait drive enable, low
  input wire logic own_mailbox_flag_n, // this port's mailbox flag
  output logic role_select // high: device arbitrates
);
  import dpsem_pkg::*;

  localparam logic [AW-1:0] OWN_MBOX = LEFT_PORT ? MBOX_LEFT : MBOX_RIGHT;
  // setup outlasts the wait filter so a collision stalls before any strobe
  localparam logic [CNT_W-1:0] SETUP_LOAD = CNT_W'(SETUP_CYC + SYNC_CYC);
  localparam logic [CNT_W-1:0] STROBE_LOAD = CNT_W'(STROBE_CYC + SYNC_CYC - 1);

  state_t state, next_state;
  op_t op;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [1:0] ctrl;
  logic [DW-1:0] rdata;
  logic init_pend, done, stall_seen;
  logic [DW+1:0] s1, s2, s3;
  logic wait_f, mbox_f;

  // three-stage input sync; a change counts when stages two and three agree
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= '1;
      s2 <= '1;
      s3 <= '1;
      wait_f <= 1'b1;
      mbox_f <= 1'b1;
    end else begin
      s1 <= {&collision_wait_in_n, own_mailbox_flag_n, data_in};
      s2 <= s1;
      s3 <= s2;
      if (s2[DW+1] == s3[DW+1]) wait_f <= s3[DW+1];
      if (s2[DW] == s3[DW]) mbox_f <= s3[DW];
    end
  end

  wire data_stable = (s2[DW-1:0] == s3[DW-1:0]);
  wire is_tok = (op == OP_TOK_RD) || (op == OP_TOK_WR);
  wire is_wr = (op == OP_MEM_WR) || (op == OP_TOK_WR);
  wire act = (state == S_SETUP) || (state == S_STROBE) || (state == S_STALL);
  wire stall_req = ctrl[CTRL_MASTER] && !wait_f && !is_tok;

  // apb decode
  wire acc = psel && penable;
  wire wr_en = acc && pwrite;
  wire mapped = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_ADDR) ||
                (paddr == OFS_WDATA) || (paddr == OFS_RDATA) || (paddr == OFS_STATUS);
  wire start = wr_en && (paddr == OFS_CMD) && (state == S_IDLE) && !init_pend;
  wire launch_init = (state == S_IDLE) && init_pend;
  wire done_clr = wr_en && (paddr == OFS_STATUS) && pwdata[ST_DONE];
  wire stall_clr = wr_en && (paddr == OFS_STATUS) && pwdata[ST_STALL];
  wire [31:0] status = {27'h0, wait_f, !mbox_f, stall_seen, done, state != S_IDLE};
  assign pready = 1'b1;
  assign pslverr = acc && !mapped;
  assign prdata = (paddr == OFS_CTRL) ? {30'h0, ctrl} :
                  (paddr == OFS_ADDR) ? {16'h0, addr} :
                  (paddr == OFS_WDATA) ? {14'h0, data_out} :
                  (paddr == OFS_RDATA) ? {14'h0, rdata} :
                  (paddr == OFS_STATUS) ? status : 32'h0;

  // pin strobes decoded from state and op; role and wait pins from ctrl
  assign port_select_low_active_n = !(act && !is_tok);
  assign port_select_high_active = act && !is_tok;
  assign token_space_select_n = !(act && is_tok);
  assign rw_n = !((state == S_STROBE) && is_wr);
  assign oe_n = !((state == S_STROBE) && !is_wr);
  assign data_oe_n = !(act && is_wr);
  assign role_select = ctrl[CTRL_MASTER];
  assign collision_wait_oe_n = ctrl[CTRL_MASTER];
  assign collision_wait_out_n = !ctrl[CTRL_BLOCK];

  always_comb begin
    next_state = state;
    next_cnt = cnt;
    case (state)
      S_IDLE: begin
        if (start || launch_init) begin
          next_state = S_SETUP;
          next_cnt = SETUP_LOAD;
        end
      end
      S_SETUP: begin
        if (cnt != '0) begin
          next_cnt = cnt - 1'b1;
        end else if (stall_req) begin
          next_state = S_STALL;
        end else begin
          next_state = S_STROBE;
          next_cnt = STROBE_LOAD;
        end
      end
      S_STALL: begin
        if (!stall_req) begin
          next_state = S_SETUP;
          next_cnt = SETUP_LOAD;
        end
      end
      S_STROBE: begin
        if (cnt != '0) next_cnt = cnt - 1'b1;
        else if (is_wr || data_stable) next_state = S_RECOV;
      end
      S_RECOV: next_state = S_IDLE;
      default: next_state = S_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= S_IDLE;
      cnt <= '0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // init reads own mailbox once, clearing its flag
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_pend <= 1'b1;
      op <= OP_MEM_RD;
      addr <= '0;
    end else if (launch_init) begin
      init_pend <= 1'b0;
      op <= OP_MEM_RD;
      addr <= OWN_MBOX;
    end else if (start) begin
      op <= op_t'(pwdata[1:0]);
    end else if (wr_en && (paddr == OFS_ADDR) && (state == S_IDLE)) begin
      addr <= pwdata[AW-1:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RESET;
      data_out <= '0;
      rdata <= '0;
      done <= 1'b0;
      stall_seen <= 1'b0;
    end else begin
      if (wr_en && (paddr == OFS_CTRL)) ctrl <= pwdata[1:0];
      // token writes use data bit zero only
      if (wr_en && (paddr == OFS_WDATA) && (state == S_IDLE)) data_out <= pwdata[DW-1:0];
      if ((state == S_STROBE) && (next_state == S_RECOV) && !is_wr) rdata <= s3[DW-1:0];
      done <= (state == S_RECOV) || (done && !done_clr);
      stall_seen <= (state == S_STALL) || (stall_seen && !stall_clr);
    end
  end

  sequence seq_stall_hold;
    (state == S_STALL) && stall_req;
  endsequence
  sequence seq_resume;
    (state == S_STALL) && !stall_req;
  endsequence

  a_stall_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    seq_stall_hold |=> (state == S_STALL) && rw_n && oe_n && !port_select_low_active_n)
    else $error("stall left early or strobed");
  a_stall_resume: assert property (@(posedge pclk) disable iff (!presetn)
    seq_resume |=> (state == S_SETUP))
    else $error("stall did not resume");
  a_token_enables: assert property (@(posedge pclk) disable iff (!presetn)
    !token_space_select_n |-> port_select_low_active_n && !port_select_high_active)
    else $error("token access with memory enabled");
  a_role_drive: assert property (@(posedge pclk) disable iff (!presetn)
    collision_wait_oe_n == role_select)
    else $error("wait pin driven in wrong role");
  a_block_level: assert property (@(posedge pclk) disable iff (!presetn)
    (!role_select && !ctrl[CTRL_BLOCK]) |-> collision_wait_out_n)
    else $error("wait pin low without block");
  a_init_mbox: assert property (@(posedge pclk) disable iff (!presetn)
    $rose(init_pend == 1'b0) |-> ##[1:8] (!oe_n && (addr == OWN_MBOX)))
    else $error("own mailbox not read after reset");
  a_write_data: assert property (@(posedge pclk) disable iff (!presetn)
    !rw_n |-> !data_oe_n && $stable(data_out) && $stable(addr))
    else $error("write strobe without stable data");
  a_read_len: assert property (@(posedge pclk) disable iff (!presetn)
    $fell(oe_n) |-> !oe_n [*4])
    else $error("read strobe too short");
  a_done_after: assert property (@(posedge pclk) disable iff (!presetn)
    (state == S_RECOV) |=> done)
    else $error("done not set");
endmodule
`default_nettype wire

// *** dpsem_host_tb.sv ***
/*
 Self-checking bench of the host controller with the device model.
 Assumes the controller answers APB within 19 access cycles.
*/
`timescale 1ns/1ps
`default_nettype none
module dpsem_host_tb;
  import dpsem_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0, r, s;
  logic [31:0] prdata;
  logic pready, pslverr, en_n, en_h, tok_n, rw_n, oe_n, doe_n, wo_n, woe_n, role, wait_n, mbox_n;
  logic lerr;
  logic [15:0] maddr;
  logic [17:0] dhost, ddev;
  wire [17:0] dw = doe_n ? ddev : dhost;
  int err_total = 0, n_tests = 0;
  logic [15:0] ra [4] = '{16'h0000, 16'h1234, 16'hFFFE, 16'hFFFF};
  logic [17:0] rd [4] = '{18'h3FFFF, 18'h00001, 18'h2AAAA, 18'h15555};
  always #20 pclk = ~pclk;
  dpsem_host #(.NDEV(1), .LEFT_PORT(1'b1)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_select_low_active_n(en_n),
    .port_select_high_active(en_h), .token_space_select_n(tok_n), .rw_n(rw_n), .oe_n(oe_n),
    .addr(maddr), .data_in(dw), .data_out(dhost), .data_oe_n(doe_n),
    .collision_wait_in_n(wait_n), .collision_wait_out_n(wo_n), .collision_wait_oe_n(woe_n),
    .own_mailbox_flag_n(mbox_n), .role_select(role));
  dpsem_dev dev_u (.clk(pclk), .en_n(en_n), .en_h(en_h), .tok_n(tok_n), .rw_n(rw_n), .oe_n(oe_n),
    .addr(maddr), .din(dw), .role(role), .wo_n(wo_n), .woe_n(woe_n), .dout(ddev),
    .wait_n(wait_n), .mbox_n(mbox_n));
  task end_sim;
    if (err_total == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k = 0;
    @(posedge pclk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do begin @(posedge pclk); k++; end while (pready !== 1'b1 && k < 20);
    if (k >= 20) begin err_total++; end_sim(); end
    r = prdata;
    lerr = pslverr;
    psel <= 0; penable <= 0;
  endtask
  task automatic idle;
    int k = 0;
    do begin apb(0, OFS_STATUS, 0); k++; end while (r[ST_BUSY] !== 1'b0 && k < 50);
    if (k >= 50) begin err_total++; end_sim(); end
  endtask
  task automatic issue(input op_t c, input logic [15:0] a, input logic [17:0] d);
    apb(1, OFS_ADDR, {16'h0, a});
    apb(1, OFS_WDATA, {14'h0, d});
    apb(1, OFS_CMD, {30'h0, c});
  endtask
  task automatic op(input op_t c, input logic [15:0] a, input logic [17:0] d);
    issue(c, a, d);
    idle();
    apb(0, OFS_RDATA, 0);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    chk("reset pins", 32'h3F, {en_n, tok_n, rw_n, role, woe_n, wo_n});
    presetn <= 1;
    idle();
    chk("init status", 32'h2, r & 32'hA);
    apb(0, OFS_CTRL, 0);
    chk("ctrl reset", 32'h1, r);
    apb(0, 8'h3C, 0);
    chk("unmapped", 32'h1, {r[30:0], lerr});
    foreach (ra[i]) op(OP_MEM_WR, ra[i], rd[i]);
    foreach (ra[i]) begin
      op(OP_MEM_RD, ra[i], 0);
      chk("row read", {14'h0, rd[i]}, r);
    end
    chk("right flag", 32'h0, dev_u.rflag_n);
    dev_u.far_wr(16'hFFFE, 18'h0F0F0);
    repeat (4) @(posedge pclk);
    apb(0, OFS_STATUS, 0);
    chk("mbox set", 32'h8, r & 32'h8);
    op(OP_MEM_RD, 16'hFFFE, 0);
    chk("mbox word", 32'h0F0F0, r);
    apb(0, OFS_STATUS, 0);
    chk("mbox clear", 32'h0, r & 32'h8);
    for (int i = 0; i < 8; i++) begin
      op(OP_TOK_WR, 16'(i), 0);
      op(OP_TOK_RD, 16'(i), 0);
      chk("tok grant", 32'h0, r | 32'(dev_u.hold[i] != 1));
      op(OP_TOK_WR, 16'(i), 1);
      op(OP_TOK_RD, 16'(i), 0);
      chk("tok free", 32'h3FFFF, r);
    end
    op(OP_TOK_WR, 16'h5, 0);
    dev_u.tok_wr(2, 5, 0);
    op(OP_TOK_RD, 16'h5, 0);
    chk("tok keep", 32'h0, r);
    op(OP_TOK_WR, 16'h5, 1);
    op(OP_TOK_RD, 16'h5, 0);
    chk("tok pass", 32'h3FFFF, r | 32'(dev_u.hold[5] != 2));
    op(OP_TOK_WR, 16'h5, 0);
    dev_u.tok_wr(2, 5, 1);
    op(OP_TOK_RD, 16'h5, 0);
    chk("tok back", 32'h0, r);
    op(OP_TOK_WR, 16'h5, 1);
    dev_u.opp_en = 1;
    dev_u.opp_addr = 16'h0101;
    op(OP_MEM_WR, 16'h0100, 18'h00ABC);
    apb(0, OFS_STATUS, 0);
    chk("no match", 32'h0, r & 32'h4);
    dev_u.opp_addr = 16'h0100;
    issue(OP_MEM_WR, 16'h0100, 18'h00DEF);
    repeat (10) @(posedge pclk);
    chk("stall strobe", 32'h1, rw_n);
    apb(0, OFS_STATUS, 0);
    chk("stall status", 32'h5, r & 32'h15);
    dev_u.opp_en = 0;
    idle();
    op(OP_MEM_RD, 16'h0100, 0);
    chk("after stall", 32'hDEF, r);
    apb(1, OFS_CTRL, 32'h2);
    @(negedge pclk);
    chk("slave pins", 32'h0, {role, woe_n, wo_n});
    op(OP_MEM_WR, 16'h0100, 18'h00123);
    apb(1, OFS_CTRL, 32'h0);
    op(OP_MEM_RD, 16'h0100, 0);
    chk("slave block", 32'hDEF, r);
    presetn <= 0;
    repeat (2) @(posedge pclk);
    chk("reset role", 32'h3, {role, woe_n});
    presetn <= 1;
    idle();
    chk("reinit status", 32'h2, r & 32'hA);
    end_sim();
  end
endmodule
`default_nettype wire

// *** dpsem_pkg.sv ***
/*
 Constants and types of the host-side controller for the dual-port
 memory: register map, field positions, pin timing and state codes.
 Assumes a 25 MHz APB clock and one memory port per controller.
*/
// Operation
// - In input role outside logic holds wait high, or low to forbid writes.
// - A port seeing low wait may hold off its access until released.
// - Token access uses memory enable inactive and token-space select active.
// - Stacked devices' active-low wait indications are ANDed together.
// - Outside logic initialises both mailbox flags after power-up; the controller reads only its own mailbox after reset.
package dpsem_pkg;
  localparam int CLK_MHZ = 25;
  localparam int T_SETUP_NS = 5;
  localparam int T_STROBE_NS = 20;
  localparam int SETUP_CYC = (T_SETUP_NS * CLK_MHZ + 999) / 1000;
  localparam int STROBE_CYC = (T_STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int SYNC_CYC = 3;
  localparam int CNT_W = 4;
  localparam int AW = 16;
  localparam int DW = 18;
  localparam int TOK_W = 3;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_ADDR = 8'h08;
  localparam logic [7:0] OFS_WDATA = 8'h0C;
  localparam logic [7:0] OFS_RDATA = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam int CTRL_MASTER = 0;
  localparam int CTRL_BLOCK = 1;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_STALL = 2;
  localparam int ST_MBOX = 3;
  localparam int ST_WAIT = 4;
  localparam logic [AW-1:0] MBOX_LEFT = 16'hFFFE;
  localparam logic [AW-1:0] MBOX_RIGHT = 16'hFFFF;
  typedef enum logic [1:0] {
    OP_MEM_RD = 2'h0,
    OP_MEM_WR = 2'h1,
    OP_TOK_RD = 2'h2,
    OP_TOK_WR = 2'h3
  } op_t;
  typedef enum logic [2:0] {
    S_IDLE = 3'h0,
    S_SETUP = 3'h1,
    S_STROBE = 3'h3,
    S_RECOV = 3'h2,
    S_STALL = 3'h5
  } state_t;
endpackage
